//--- inc/offset_filter_params.svh
// Constants of the offset cancellation filter: timing, coefficients, codes
`ifndef OFFSET_FILTER_PARAMS_SVH
`define OFFSET_FILTER_PARAMS_SVH

// Core clock and microsecond time base
`define OC_CLK_PERIOD_NS 10
`define OC_US_NS 1000
`define OC_US_CYC (`OC_US_NS / `OC_CLK_PERIOD_NS)

// Sample time and phase start times from reset, in microseconds
`define OC_SAMPLE_US 256
`define OC_PH1_START_US 4096
`define OC_PH2_START_US 8192
`define OC_PH3_START_US 24580
`define OC_PH4_START_US 90110
`define OC_PH5_START_US 352300
`define OC_NORMAL_START_US 1401000

// Output freeze extension after self-test, in microseconds
`define OC_ST_FREEZE_US 15000

// Coefficients, 24-bit unsigned fractions scaled by 2^24.
// The feedback term is stored as the magnitude of the negative d1.
`define OC_N0 24'h7ffffe
`define OC_N1 24'h7ffffe
`define OC_A0_PH0 24'h3beacc
`define OC_D1_PH0 24'hc41532
`define OC_A0_PH1 24'h105578
`define OC_D1_PH1 24'hefaa86
`define OC_A0_PH2 24'h042ea6
`define OC_D1_PH2 24'hfbd158
`define OC_A0_PH3 24'h010d4e
`define OC_D1_PH3 24'hfef2b0
`define OC_A0_PH4 24'h00436e
`define OC_D1_PH4 24'hffbc90
`define OC_A0_PH5 24'h0010dc
`define OC_D1_PH5 24'hffef22
`define OC_A0_LOW 24'h000437
`define OC_D1_LOW 24'hfffbc7

// Offset filter select codes used in normal mode
`define OC_SEL_LOW 2'h0
`define OC_SEL_LOW_RL 2'h1
`define OC_SEL_MID 2'h2
`define OC_SEL_HIGH 2'h3

// Self-test control bit that marks analog or digital self-test
`define OC_ST_ACTIVE_BIT 3

// Reset values
`define OC_OUT_RST 16'h0000

`endif

//--- inc/offset_filter_pkg.sv
// Types shared by the offset cancellation filter modules
package offset_filter_pkg;

	typedef struct packed {
		logic [23:0] a0;
		logic [23:0] n0;
		logic [23:0] n1;
		logic [23:0] d1_mag;
	} coef_t;

	typedef enum logic [2:0] {
		PH_0,
		PH_1,
		PH_2,
		PH_3,
		PH_4,
		PH_5,
		PH_NORMAL
	} phase_t;

	typedef struct packed {
		logic [7:0] step_lsb;
		logic [7:0] interval;
	} rate_limit_cfg_t;

endpackage

//--- hw/offset_iir_stage.sv
// First-order recursive low-pass stage of the offset estimator
`timescale 1ns/1ns
`include "offset_filter_params.svh"

module offset_iir_stage
	import offset_filter_pkg::*;
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic sample_stb,
	input wire logic signed [15:0] x_in,
	input coef_t coef,
	output logic signed [15:0] y_out
);

	logic signed [15:0] x1_r;
	logic signed [15:0] x1_nxt;
	// State keeps 24 fraction bits so tiny a0 values still integrate
	logic signed [47:0] y_r;
	logic signed [47:0] y_nxt;
	logic signed [41:0] sum_q;
	logic signed [66:0] fwd_p;
	logic signed [72:0] fb_p;

	always_comb begin
		sum_q = 42'(x_in) * 42'($signed({1'b0, coef.n0}))
			+ 42'(x1_r) * 42'($signed({1'b0, coef.n1}));
		fwd_p = 67'(sum_q) * 67'($signed({1'b0, coef.a0}));
		fb_p = 73'(y_r) * 73'($signed({1'b0, coef.d1_mag}));
		x1_nxt = x1_r;
		y_nxt = y_r;
		if (sample_stb) begin
			x1_nxt = x_in;
			y_nxt = 48'(fwd_p >>> 24) + 48'(fb_p >>> 24);
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			x1_r <= 16'sh0000;
			y_r <= 48'sh000000000000;
		end else begin
			x1_r <= x1_nxt;
			y_r <= y_nxt;
		end
	end

	assign y_out = y_r[39:24];

endmodule

//--- hw/offset_cancellation_filter.sv
// Offset cancellation: startup phases, rate limiting, self-test freeze
//
// Contract
// - Offset estimator is a first-order recursive low-pass with a0, n0, n1, d0, d1.
// - After reset, step through startup phases each with its own coefficients.
// - Rate limiting is bypassed in every startup phase regardless of select field.
// - Normal mode takes corner and rate limiting from the offset filter select.
// - Rate limiting only takes effect with the lowest corner selected.
// - Rate limited output moves by at most step LSB per interval.
// - Output holds while self-test control is 8 to 15, in any phase.
// - After self-test ends the output stays frozen 15 ms more.
// - Phase one starts 4.096 ms after reset; sampling every 256 us.
// - Startup phases use n0 = n1 just under one half and d0 = one.
`timescale 1ns/1ns
`include "offset_filter_params.svh"

module offset_cancellation_filter
	import offset_filter_pkg::*;
#(
	parameter int unsigned SAMPLE_US = `OC_SAMPLE_US,
	parameter int unsigned PH1_START_US = `OC_PH1_START_US,
	parameter int unsigned PH2_START_US = `OC_PH2_START_US,
	parameter int unsigned PH3_START_US = `OC_PH3_START_US,
	parameter int unsigned PH4_START_US = `OC_PH4_START_US,
	parameter int unsigned PH5_START_US = `OC_PH5_START_US,
	parameter int unsigned NORMAL_START_US = `OC_NORMAL_START_US,
	parameter int unsigned ST_FREEZE_US = `OC_ST_FREEZE_US
)(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic signed [15:0] data_in,
	input wire logic [1:0] offset_filter_select,
	input wire logic [3:0] selftest_control,
	input rate_limit_cfg_t rate_limit_cfg,
	output logic signed [15:0] offset_out_r,
	output phase_t phase_r,
	output logic freeze_r,
	output logic sample_stb_r
);

	localparam int unsigned US_CYC = `OC_US_CYC;

	////////////////////////////////////////////////////////////////////////
	// Microsecond time base and sample strobe

	logic [6:0] us_div_r;
	logic [6:0] us_div_nxt;
	logic us_tick;
	logic [20:0] us_time_r;
	logic [20:0] us_time_nxt;
	logic [8:0] smp_cnt_r;
	logic [8:0] smp_cnt_nxt;
	logic sample_stb_nxt;

	always_comb begin
		us_tick = (us_div_r == 7'(US_CYC - 1));
		us_div_nxt = us_tick ? 7'h00 : us_div_r + 7'h01;
		us_time_nxt = us_time_r;
		smp_cnt_nxt = smp_cnt_r;
		sample_stb_nxt = 1'b0;
		if (us_tick) begin
			// Time since reset stops once normal mode is reached
			if (phase_r != PH_NORMAL) begin
				us_time_nxt = us_time_r + 21'h000001;
			end
			if (smp_cnt_r == 9'(SAMPLE_US - 1)) begin
				smp_cnt_nxt = 9'h000;
				sample_stb_nxt = 1'b1;
			end else begin
				smp_cnt_nxt = smp_cnt_r + 9'h001;
			end
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			us_div_r <= 7'h00;
			us_time_r <= 21'h000000;
			smp_cnt_r <= 9'h000;
			sample_stb_r <= 1'b0;
		end else begin
			us_div_r <= us_div_nxt;
			us_time_r <= us_time_nxt;
			smp_cnt_r <= smp_cnt_nxt;
			sample_stb_r <= sample_stb_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Startup phase sequencer

	phase_t phase_nxt;

	always_comb begin
		phase_nxt = phase_r;
		case (phase_r)
			PH_0: begin
				if (us_time_r >= 21'(PH1_START_US)) begin
					phase_nxt = PH_1;
				end
			end
			PH_1: begin
				if (us_time_r >= 21'(PH2_START_US)) begin
					phase_nxt = PH_2;
				end
			end
			PH_2: begin
				if (us_time_r >= 21'(PH3_START_US)) begin
					phase_nxt = PH_3;
				end
			end
			PH_3: begin
				if (us_time_r >= 21'(PH4_START_US)) begin
					phase_nxt = PH_4;
				end
			end
			PH_4: begin
				if (us_time_r >= 21'(PH5_START_US)) begin
					phase_nxt = PH_5;
				end
			end
			PH_5: begin
				if (us_time_r >= 21'(NORMAL_START_US)) begin
					phase_nxt = PH_NORMAL;
				end
			end
			PH_NORMAL: begin
				phase_nxt = PH_NORMAL;
			end
			default: begin
				phase_nxt = PH_0;
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			phase_r <= PH_0;
		end else begin
			phase_r <= phase_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Coefficient selection

	coef_t coef;
	logic rl_active;

	always_comb begin
		coef.n0 = `OC_N0;
		coef.n1 = `OC_N1;
		coef.a0 = `OC_A0_LOW;
		coef.d1_mag = `OC_D1_LOW;
		rl_active = 1'b0;
		case (phase_r)
			PH_0: begin
				coef.a0 = `OC_A0_PH0;
				coef.d1_mag = `OC_D1_PH0;
			end
			PH_1: begin
				coef.a0 = `OC_A0_PH1;
				coef.d1_mag = `OC_D1_PH1;
			end
			PH_2: begin
				coef.a0 = `OC_A0_PH2;
				coef.d1_mag = `OC_D1_PH2;
			end
			PH_3: begin
				coef.a0 = `OC_A0_PH3;
				coef.d1_mag = `OC_D1_PH3;
			end
			PH_4: begin
				coef.a0 = `OC_A0_PH4;
				coef.d1_mag = `OC_D1_PH4;
			end
			PH_5: begin
				coef.a0 = `OC_A0_PH5;
				coef.d1_mag = `OC_D1_PH5;
			end
			PH_NORMAL: begin
				case (offset_filter_select)
					`OC_SEL_LOW_RL: begin
						rl_active = 1'b1;
					end
					`OC_SEL_MID: begin
						coef.a0 = `OC_A0_PH5;
						coef.d1_mag = `OC_D1_PH5;
					end
					`OC_SEL_HIGH: begin
						coef.a0 = `OC_A0_PH4;
						coef.d1_mag = `OC_D1_PH4;
					end
					default: begin
						rl_active = 1'b0;
					end
				endcase
			end
			default: begin
				rl_active = 1'b0;
			end
		endcase
	end

	logic signed [15:0] filt_y;

	offset_iir_stage u_iir (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.sample_stb(sample_stb_r),
		.x_in(data_in),
		.coef(coef),
		.y_out(filt_y)
	);

	////////////////////////////////////////////////////////////////////////
	// Self-test freeze and output update

	logic st_active;
	logic st_active_r;
	logic [13:0] frz_cnt_r;
	logic [13:0] frz_cnt_nxt;
	logic freeze_nxt;
	logic [7:0] rl_cnt_r;
	logic [7:0] rl_cnt_nxt;
	logic [7:0] rl_last;
	logic signed [16:0] diff;
	logic signed [16:0] step_s;
	logic signed [15:0] out_nxt;

	always_comb begin
		st_active = selftest_control[`OC_ST_ACTIVE_BIT];
		frz_cnt_nxt = frz_cnt_r;
		if (st_active) begin
			frz_cnt_nxt = 14'h0000;
		end else if (st_active_r) begin
			frz_cnt_nxt = 14'(ST_FREEZE_US);
		end else if (us_tick && frz_cnt_r != 14'h0000) begin
			frz_cnt_nxt = frz_cnt_r - 14'h0001;
		end
		freeze_nxt = st_active || st_active_r || (frz_cnt_nxt != 14'h0000);
		// A zero interval is taken as one sample
		rl_last = (rate_limit_cfg.interval == 8'h00) ? 8'h00
			: rate_limit_cfg.interval - 8'h01;
		diff = 17'(filt_y) - 17'(offset_out_r);
		step_s = $signed({9'h000, rate_limit_cfg.step_lsb});
		rl_cnt_nxt = rl_cnt_r;
		out_nxt = offset_out_r;
		if (freeze_r || freeze_nxt) begin
			out_nxt = offset_out_r;
		end else if (!rl_active) begin
			rl_cnt_nxt = 8'h00;
			out_nxt = filt_y;
		end else if (sample_stb_r) begin
			if (rl_cnt_r >= rl_last) begin
				rl_cnt_nxt = 8'h00;
				if (diff > step_s) begin
					out_nxt = offset_out_r + 16'(step_s);
				end else if (diff < -step_s) begin
					out_nxt = offset_out_r - 16'(step_s);
				end else begin
					out_nxt = filt_y;
				end
			end else begin
				rl_cnt_nxt = rl_cnt_r + 8'h01;
			end
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_active_r <= 1'b0;
			frz_cnt_r <= 14'h0000;
			freeze_r <= 1'b0;
			rl_cnt_r <= 8'h00;
			offset_out_r <= `OC_OUT_RST;
		end else begin
			st_active_r <= st_active;
			frz_cnt_r <= frz_cnt_nxt;
			freeze_r <= freeze_nxt;
			rl_cnt_r <= rl_cnt_nxt;
			offset_out_r <= out_nxt;
		end
	end

endmodule

//--- sim/offset_filter_checker.sv
// Port assertions of the offset cancellation filter
`timescale 1ns/1ns
`include "offset_filter_params.svh"
module offset_filter_checker
	import offset_filter_pkg::*;
#(
	parameter int unsigned SAMPLE_US = `OC_SAMPLE_US,
	parameter int unsigned ST_FREEZE_US = `OC_ST_FREEZE_US
)(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic signed [15:0] data_in,
	input wire logic [1:0] offset_filter_select,
	input wire logic [3:0] selftest_control,
	input rate_limit_cfg_t rate_limit_cfg,
	input wire logic signed [15:0] offset_out_r,
	input phase_t phase_r,
	input wire logic freeze_r,
	input wire logic sample_stb_r
);
////////////////////////////////////////
localparam int STB_P = SAMPLE_US * `OC_US_CYC;
// Tail counts whole microsecond ticks, so allow two extra ticks of slack
localparam int TAIL_MAX = ST_FREEZE_US * `OC_US_CYC + 200;
// Long intervals are counted here, too long for a delay range
int stb_gap;
logic stb_seen;
int tail_cnt;
logic signed [15:0] out_q;
logic signed [16:0] delta;
logic signed [16:0] step;
logic rl_on;
always_ff @(posedge core_clk or posedge sys_rst) begin
	if (sys_rst) begin
		out_q <= 16'sh0000;
		stb_gap <= 0;
		stb_seen <= 1'b0;
		tail_cnt <= 0;
	end else begin
		out_q <= offset_out_r;
		stb_gap <= sample_stb_r ? 0 : stb_gap + 1;
		stb_seen <= stb_seen || sample_stb_r;
		tail_cnt <= (selftest_control[3] || !freeze_r) ? 0 : tail_cnt + 1;
	end
end
assign delta = {offset_out_r[15], offset_out_r} - {out_q[15], out_q};
assign step = {9'h000, rate_limit_cfg.step_lsb};
assign rl_on = phase_r == PH_NORMAL && offset_filter_select == 2'h1
	&& !freeze_r && !selftest_control[3];
default clocking cb @(posedge core_clk); endclocking
default disable iff (sys_rst);
sequence s_st_off; $fell(selftest_control[3]); endsequence
sequence s_tail_held; freeze_r [*8]; endsequence
property p_st_freeze; selftest_control[3] |=> freeze_r; endproperty
property p_st_hold; selftest_control[3] |=> $stable(offset_out_r); endproperty
property p_tail_hold; s_st_off |-> s_tail_held; endproperty
property p_tail_end; tail_cnt <= TAIL_MAX; endproperty
property p_phase_step;
	phase_r != $past(phase_r) |-> 3'(phase_r) == 3'($past(phase_r)) + 3'h1;
endproperty
property p_stb_pulse; sample_stb_r |=> !sample_stb_r; endproperty
property p_stb_period;
	stb_seen |-> (sample_stb_r ? stb_gap == STB_P - 1 : stb_gap < STB_P - 1);
endproperty
property p_rl_quiet; rl_on && !sample_stb_r |=> $stable(offset_out_r); endproperty
property p_rl_step;
	rl_on && sample_stb_r |=> delta <= step && delta >= -step;
endproperty
a_st_freeze: assert property (p_st_freeze)
	else $error("freeze flag low in self-test");
a_st_hold: assert property (p_st_hold)
	else $error("output moved in self-test");
a_tail_hold: assert property (p_tail_hold)
	else $error("freeze tail too short");
a_tail_end: assert property (p_tail_end)
	else $error("freeze tail too long");
a_phase_step: assert property (p_phase_step)
	else $error("phase skipped");
a_stb_pulse: assert property (p_stb_pulse)
	else $error("sample strobe too wide");
a_stb_period: assert property (p_stb_period)
	else $error("sample period wrong");
a_rl_quiet: assert property (p_rl_quiet)
	else $error("limited output moved off strobe");
a_rl_step: assert property (p_rl_step)
	else $error("limited output step too large");
endmodule
bind offset_cancellation_filter offset_filter_checker #(
	.SAMPLE_US(SAMPLE_US), .ST_FREEZE_US(ST_FREEZE_US)
) offset_filter_checker_i (.core_clk(core_clk), .sys_rst(sys_rst),
	.data_in(data_in), .offset_filter_select(offset_filter_select),
	.selftest_control(selftest_control), .rate_limit_cfg(rate_limit_cfg),
	.offset_out_r(offset_out_r), .phase_r(phase_r), .freeze_r(freeze_r),
	.sample_stb_r(sample_stb_r));

//--- sim/offset_cancellation_filter_bench.sv
// Self-checking bench of the offset cancellation filter
`timescale 1ns/1ns
`include "offset_filter_params.svh"
module offset_cancellation_filter_bench
	import offset_filter_pkg::*;
;
////////////////////////////////////////
logic core_clk = 1'b0;
logic sys_rst = 1'b1;
logic signed [15:0] data_in = 16'sh0000;
logic signed [15:0] din_fix = 16'sh0000;
logic [1:0] sel = 2'h0;
logic [3:0] st = 4'h0;
rate_limit_cfg_t rl = 16'h0101;
logic signed [15:0] offset_out_r;
phase_t phase_r;
logic freeze_r;
logic sample_stb_r;
logic rnd = 1'b1;
int n_mismatch = 0;
int checked = 0;
int cyc = 0;
int last = 0;
int maxd;
int sumd;
int s;
int e;
int calm = 0;
real my = 0.0;
real mx1 = 0.0;
real ca;
always #5 core_clk = ~core_clk;
// Short phase times keep the whole startup within a few thousand cycles
localparam int unsigned T_SMP = 2;
localparam int unsigned T_PH1 = 4;
localparam int unsigned T_PH2 = 8;
localparam int unsigned T_PH3 = 12;
localparam int unsigned T_PH4 = 16;
localparam int unsigned T_PH5 = 20;
localparam int unsigned T_NRM = 24;
localparam int unsigned T_FRZ = 5;
offset_cancellation_filter #(.SAMPLE_US(T_SMP), .PH1_START_US(T_PH1),
	.PH2_START_US(T_PH2), .PH3_START_US(T_PH3), .PH4_START_US(T_PH4),
	.PH5_START_US(T_PH5), .NORMAL_START_US(T_NRM), .ST_FREEZE_US(T_FRZ)
) offset_cancellation_filter_i (.core_clk(core_clk), .sys_rst(sys_rst),
	.data_in(data_in), .offset_filter_select(sel),
	.selftest_control(st), .rate_limit_cfg(rl),
	.offset_out_r(offset_out_r), .phase_r(phase_r),
	.freeze_r(freeze_r), .sample_stb_r(sample_stb_r));
task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
	checked++;
	if (seen !== exp) begin
		n_mismatch++;
		$display("wrong value at %0t: %h, expected %h", $time, seen, exp);
	end
endtask
task automatic test_done();
	$display("checked %0d n_mismatch %0d", checked, n_mismatch);
	if (n_mismatch == 0 && checked > 0) begin
		$display("STATUS OK");
	end else begin
		$display("STATUS NOT OK");
	end
	$finish;
endtask
// Gain of the phase and select in use, as a fraction of one
function automatic real gain_of(input int ph, input logic [1:0] sl);
	logic [23:0] a;
	case (ph)
		0: a = `OC_A0_PH0;
		1: a = `OC_A0_PH1;
		2: a = `OC_A0_PH2;
		3: a = `OC_A0_PH3;
		4: a = `OC_A0_PH4;
		5: a = `OC_A0_PH5;
		default: begin
			a = `OC_A0_LOW;
			if (sl == 2'h2) a = `OC_A0_PH5;
			if (sl == 2'h3) a = `OC_A0_PH4;
		end
	endcase
	return a / 16777216.0;
endfunction
// Largest and summed output change over n cycles
task automatic run(input int n);
	int p;
	int d;
	p = offset_out_r;
	maxd = 0;
	sumd = 0;
	repeat (n) begin
		@(negedge core_clk);
		d = offset_out_r - p;
		p = offset_out_r;
		sumd += d;
		if (d > maxd || -d > maxd) maxd = d < 0 ? -d : d;
	end
endtask
// One driver for the sample input, so a fixed level never races a random one
always @(negedge core_clk) data_in <= rnd ? 16'($urandom) : din_fix;
always @(posedge core_clk) begin
	if (!sys_rst) begin
		cyc++;
		if (cyc % 100 == 50) chk(phase_r, cyc >= 2400 ? 6 : cyc / 400);
		calm = (freeze_r || (phase_r == PH_NORMAL && sel == 2'h1)) ? 0
			: calm + 1;
		if (sample_stb_r) begin
			// Reference filter in real arithmetic; one LSB of slack
			// covers the truncation of the fixed-point state
			if (calm >= 2) begin
				e = $rtoi(my);
				if (e > my) e--;
				chk(offset_out_r >= e - 1 && offset_out_r <= e + 1,
					1'b1);
			end
			ca = gain_of(phase_r, sel);
			my = ca * 0.49999988079071 * (data_in + mx1)
				+ (16777214.0 / 16777216.0 - ca) * my;
			mx1 = data_in;
			if (last > 0) chk(cyc - last, T_SMP * 100);
			last = cyc;
		end
		if (cyc > 20000) begin
			n_mismatch++;
			test_done();
		end
	end
end
initial begin
	void'($urandom(32'hd146));
	repeat (3) @(posedge core_clk);
	@(negedge core_clk);
	sys_rst = 1'b0;
	run(600);
	st = 4'h8 | 4'($urandom % 8);
	run(1);
	chk(freeze_r, 1'b1);
	run(300);
	chk(maxd, 0);
	st = 4'($urandom % 8);
	run(350);
	chk(freeze_r, 1'b1);
	chk(maxd, 0);
	run(250);
	chk(freeze_r, 1'b0);
	rnd = 1'b0;
	din_fix = 16'sh4000;
	sel = 2'h1;
	run(800);
	chk(maxd > 1, 1'b1);
	run(200);
	sel = 2'h3;
	din_fix = -16'sh7000;
	s = 1 + $urandom % 4;
	run(2000);
	chk(maxd > s, 1'b1);
	sel = 2'h1;
	// A zero step lets the filter run ahead, so later steps stay full size
	rl = 16'h0001;
	run(4000);
	chk(maxd, 0);
	rl = {8'(s), 8'h01};
	run(2000);
	chk(sumd, -10 * s);
	// Two samples per step: half as many steps in the same time
	rl = {8'(s), 8'h02};
	run(2000);
	chk(sumd, -5 * s);
	sel = 2'h2;
	run(600);
	chk(maxd > s, 1'b1);
	test_done();
end
endmodule
